// [design/sdp_defines.svh]
// Timing counts, field positions and reset values of the pin command block.
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH
`define SDP_ROW_W        12
`define SDP_COL_W        8
`define SDP_BANK_W       2
`define SDP_DATA_W       16
`define SDP_SCOPE_BIT    10
`define SDP_READ_MASK_LAT 2
`define SDP_READ_LAT     2
`define SDP_MODE_RESET   12'h000
`define SDP_CLK_PERIOD_NS 8
`endif

// [design/sdp_pkg.sv]
// Types shared by the pin command block.
package sdp_pkg;
    typedef enum logic [2:0] {
        SDP_CMD_NOP,
        SDP_CMD_ACTIVE,
        SDP_CMD_READ,
        SDP_CMD_WRITE,
        SDP_CMD_PRECHARGE,
        SDP_CMD_REFRESH,
        SDP_CMD_MODE_LOAD,
        SDP_CMD_BURST_STOP
    } sdp_cmd_e;
    typedef enum logic [1:0] {
        SDP_PWR_ACTIVE,
        SDP_PWR_DOWN,
        SDP_PWR_SUSPEND,
        SDP_PWR_SELF_REFRESH
    } sdp_pwr_e;
    typedef struct packed {
        logic [1:0]  bank;
        logic [7:0]  col;
        logic [15:0] data;
        logic [1:0]  mask;
    } sdp_word_s;
endpackage

// [design/sdp_pin_if.sv]
// Command and data pin logic of a four-bank 16-bit synchronous DRAM.
//
// Summary of operation
// - Active samples full twelve-bit row address.
// - Read/write column from low eight address bits.
// - Bit ten during read/write requests auto-precharge.
// - Precharge: bit ten high all banks, else one.
// - Mode load takes op-code from address inputs.
// - Bank select picks target bank for commands.
// - Command decoded from three strobes together.
// - Clock edge valid only when clock gate high.
// - Gate low means power-down, suspend or self refresh.
// - Clock gate acts without synchronisation.
// - Other inputs captured on rising clock edge.
// - Commands accepted only while select is low.
// - Select high keeps previous state unchanged.
// - Data bus controlled per byte by masks.
// - Low mask for low byte, high for upper.
// - Reads drive a byte only while mask low.
// - Writes store a byte only when mask low.
// - Read mask applied two clocks before data.
// - Write mask sampled with its data word.
`timescale 1ns/1ns
`default_nettype none
`include "sdp_defines.svh"
module sdp_pin_if
    import sdp_pkg::*;
#(
    parameter int COL_W = `SDP_COL_W,
    parameter int DEPTH = 1 << `SDP_COL_W
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic                     clock_gate_in,
    input  wire logic                     command_select_n,
    input  wire logic                     row_strobe_n,
    input  wire logic                     column_strobe_n,
    input  wire logic                     write_strobe_n,
    input  wire logic [`SDP_BANK_W-1:0]   bank_select,
    input  wire logic [`SDP_ROW_W-1:0]    addr_in,
    input  wire logic                     low_byte_mask,
    input  wire logic                     high_byte_mask,
    input  wire logic [`SDP_DATA_W-1:0]   data_in,
    output logic      [`SDP_DATA_W-1:0]   data_out,
    output logic      [1:0]               data_oe,
    output logic      [3:0]               bank_open,
    output logic      [`SDP_ROW_W-1:0]    mode_code,
    output var sdp_pwr_e                  power_state
);
    // Per-bank open rows and a small per-bank column memory.
    logic [`SDP_ROW_W-1:0]  open_row_reg [4];
    logic [`SDP_DATA_W-1:0] mem [4][DEPTH];
    logic [3:0]             bank_open_reg;
    logic                   cmd_ok;
    sdp_cmd_e               cmd;
    logic [COL_W-1:0]       col;
    // Read pipeline: address issued, then fifo feeds the pins.
    logic [1:0]             rd_pend_reg;
    logic [1:0]             rd_bank_reg [2];
    logic [COL_W-1:0]       rd_col_reg [2];
    logic [1:0]             mask_d1_reg;
    // Two-entry buffer between array and pins.
    sdp_word_s              buf_reg [2];
    logic [1:0]             buf_cnt_reg;
    logic                   buf_wr_ptr_reg;
    logic                   buf_rd_ptr_reg;
    logic                   buf_in_valid;
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic                   buf_out_ready;
    sdp_word_s              buf_in;
    logic                   bit_ap;
    logic                   auto_pre_reg;
    logic [1:0]             auto_bank_reg;

    // Three strobes decoded as one word.
    function automatic sdp_cmd_e decode(input logic r, input logic c,
                                        input logic w);
        case ({r, c, w})
            3'h3:    decode = SDP_CMD_ACTIVE;
            3'h5:    decode = SDP_CMD_READ;
            3'h4:    decode = SDP_CMD_WRITE;
            3'h2:    decode = SDP_CMD_PRECHARGE;
            3'h1:    decode = SDP_CMD_REFRESH;
            3'h0:    decode = SDP_CMD_MODE_LOAD;
            3'h6:    decode = SDP_CMD_BURST_STOP;
            default: decode = SDP_CMD_NOP;
        endcase
    endfunction

    // Edge qualification and command decode, combinational, sampled by the rising-edge blocks below.
    assign cmd_ok = clock_gate_in && !command_select_n;
    assign cmd = cmd_ok ? decode(row_strobe_n, column_strobe_n,
                                 write_strobe_n)
                        : SDP_CMD_NOP;
    assign col = addr_in[COL_W-1:0];
    assign bit_ap = addr_in[`SDP_SCOPE_BIT];

    // Bank open state, rows and auto-precharge tracking.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bank_open_reg <= 4'h0;
            auto_pre_reg  <= 1'b0;
            auto_bank_reg <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                open_row_reg[i] <= 12'h000;
            end
        end else begin
            if (clock_gate_in && auto_pre_reg && rd_pend_reg == 2'h0) begin
                bank_open_reg[auto_bank_reg] <= 1'b0;
                auto_pre_reg <= 1'b0;
            end
            case (cmd)
                SDP_CMD_ACTIVE: begin
                    bank_open_reg[bank_select] <= 1'b1;
                    open_row_reg[bank_select]  <= addr_in;
                end
                SDP_CMD_READ, SDP_CMD_WRITE: begin
                    if (bit_ap) begin
                        auto_pre_reg  <= 1'b1;
                        auto_bank_reg <= bank_select;
                    end
                end
                SDP_CMD_PRECHARGE: begin
                    if (addr_in[`SDP_SCOPE_BIT]) begin
                        bank_open_reg <= 4'h0;
                    end else begin
                        bank_open_reg[bank_select] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Mode code load from the address inputs.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_code <= `SDP_MODE_RESET;
        end else if (cmd == SDP_CMD_MODE_LOAD) begin
            mode_code <= addr_in;
        end
    end

    // Power state while the clock gate is low.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            power_state <= SDP_PWR_ACTIVE;
        end else if (!clock_gate_in) begin
            if (power_state == SDP_PWR_ACTIVE) begin
                if (cmd_ok == 1'b0 && !command_select_n
                    && decode(row_strobe_n, column_strobe_n,
                              write_strobe_n) == SDP_CMD_REFRESH) begin
                    power_state <= SDP_PWR_SELF_REFRESH;
                end else if (rd_pend_reg != 2'h0 || buf_cnt_reg != 2'h0) begin
                    power_state <= SDP_PWR_SUSPEND;
                end else begin
                    power_state <= SDP_PWR_DOWN;
                end
            end
        end else begin
            power_state <= SDP_PWR_ACTIVE;
        end
    end

    // Write path: mask sampled with the data word.
    always_ff @(posedge clock) begin
        if (cmd == SDP_CMD_WRITE && bank_open_reg[bank_select]) begin
            if (!low_byte_mask) begin
                mem[bank_select][col][7:0] <= data_in[7:0];
            end
            if (!high_byte_mask) begin
                mem[bank_select][col][15:8] <= data_in[15:8];
            end
        end
    end

    // Read address pipeline and mask delay line.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_reg <= 2'h0;
            mask_d1_reg <= 2'h3;
            for (int i = 0; i < 2; i++) begin
                rd_bank_reg[i] <= 2'h0;
                rd_col_reg[i]  <= '0;
            end
        end else if (clock_gate_in && buf_in_ready) begin
            mask_d1_reg <= {high_byte_mask, low_byte_mask};
            rd_pend_reg <= {rd_pend_reg[0],
                            cmd == SDP_CMD_READ && bank_open_reg[bank_select]};
            rd_bank_reg[0] <= bank_select;
            rd_col_reg[0]  <= col;
            rd_bank_reg[1] <= rd_bank_reg[0];
            rd_col_reg[1]  <= rd_col_reg[0];
        end
    end

    // Buffer entry from the array with the mask registered one clock earlier.
    assign buf_in_valid = clock_gate_in && rd_pend_reg[1];
    assign buf_in = '{bank: rd_bank_reg[1], col: rd_col_reg[1],
                      data: mem[rd_bank_reg[1]][rd_col_reg[1]],
                      mask: mask_d1_reg};
    assign buf_in_ready = (buf_cnt_reg != 2'h2);
    assign buf_out_valid = (buf_cnt_reg != 2'h0);
    assign buf_out_ready = clock_gate_in; // Suspend stalls the pins.

    // Two-entry buffer bookkeeping.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buf_cnt_reg    <= 2'h0;
            buf_wr_ptr_reg <= 1'b0;
            buf_rd_ptr_reg <= 1'b0;
        end else begin
            if (buf_in_valid && buf_in_ready) begin
                buf_reg[buf_wr_ptr_reg] <= buf_in;
                buf_wr_ptr_reg <= !buf_wr_ptr_reg;
            end
            if (buf_out_valid && buf_out_ready) begin
                buf_rd_ptr_reg <= !buf_rd_ptr_reg;
            end
            buf_cnt_reg <= buf_cnt_reg
                + {1'b0, buf_in_valid && buf_in_ready}
                - {1'b0, buf_out_valid && buf_out_ready};
        end
    end

    // Pin drivers: a byte is driven only with read data and its mask low.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= 16'h0000;
            data_oe  <= 2'h0;
        end else if (buf_out_valid && buf_out_ready) begin
            data_out <= buf_reg[buf_rd_ptr_reg].data;
            data_oe  <= ~buf_reg[buf_rd_ptr_reg].mask;
        end else if (clock_gate_in) begin
            data_oe  <= 2'h0;
        end
    end

    assign bank_open = bank_open_reg;
endmodule
`default_nettype wire

// [tb/sdp_pin_checker.sv]
// Concurrent checks on the pins of the command block.
`timescale 1ns/1ns
`default_nettype none
module sdp_pin_checker
    import sdp_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        clock_gate_in,
    input wire logic        command_select_n,
    input wire logic        row_strobe_n,
    input wire logic        column_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [1:0]  bank_select,
    input wire logic [11:0] addr_in,
    input wire logic        low_byte_mask,
    input wire logic        high_byte_mask,
    input wire logic [1:0]  data_oe,
    input wire logic [3:0]  bank_open,
    input wire logic [11:0] mode_code,
    input var sdp_pwr_e     power_state
);
    // A command counts only on an enabled edge with the select low.
    wire logic [2:0] cmd = {row_strobe_n, column_strobe_n, write_strobe_n};
    wire logic       take = clock_gate_in && !command_select_n;
    wire logic       rd = take && cmd == 3'h5;
    wire logic [1:0] msk = {high_byte_mask, low_byte_mask};
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_read; rd && bank_open[bank_select]; endsequence
    sequence s_run; clock_gate_in [*3]; endsequence
    a_act_opens: assert property (take && cmd == 3'h3
        |=> bank_open[$past(bank_select)]) else $error("bank not opened");
    a_pre_all: assert property (take && cmd == 3'h2 && addr_in[10]
        |=> bank_open == 4'h0) else $error("banks left open");
    a_pre_one: assert property (take && cmd == 3'h2 && !addr_in[10]
        |=> !bank_open[$past(bank_select)]) else $error("bank left open");
    a_mode_take: assert property (take && cmd == 3'h0 && !bank_open
        |=> mode_code == $past(addr_in)) else $error("op-code lost");
    a_desel_keep: assert property (command_select_n
        |=> $stable(mode_code)) else $error("deselect changed state");
    a_gate_freeze: assert property (!clock_gate_in
        |=> $stable(bank_open) && $stable(mode_code)) else $error("edge used");
    a_gate_power: assert property (!clock_gate_in [*2]
        |-> power_state != SDP_PWR_ACTIVE) else $error("still active");
    a_read_mask: assert property (s_read ##1 s_run
        |=> data_oe == ~$past(msk, 3)) else $error("read lanes wrong");
    a_idle_quiet: assert property ((!rd && clock_gate_in) [*5]
        |-> data_oe == 2'h0) else $error("bus driven when idle");
endmodule
bind sdp_pin_if sdp_pin_checker u_chk (.clock, .sys_rst, .clock_gate_in,
    .command_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n,
    .bank_select, .addr_in, .low_byte_mask, .high_byte_mask, .data_oe,
    .bank_open, .mode_code, .power_state);
`default_nettype wire

// [tb/sdp_host_model.sv]
// Controller model that drives commands and write data onto the pins.
`timescale 1ns/1ns
`default_nettype none
module sdp_host_model (
    input  wire logic        clock,
    output logic             gate,
    output logic             cs_n,
    output logic [2:0]       code,
    output logic [1:0]       ba,
    output logic [11:0]      addr,
    output logic [1:0]       mask,
    output logic [15:0]      dq
);
    // Pins start idle: clock enabled, nothing selected.
    initial begin
        gate = 1'b1;
        cs_n = 1'b1;
        code = 3'h7;
        ba   = 2'h0;
        addr = 12'h000;
        mask = 2'h3;
        dq   = 16'h0000;
    end
    // One command per falling edge; row, column, flag and op-code share addr.
    task automatic cmd(input logic [2:0] c, input logic [1:0] b,
        input logic [11:0] a, input logic [1:0] m, input logic [15:0] d,
        input logic g = 1'b1, input logic s = 1'b0);
        @(negedge clock);
        {gate, cs_n, code, ba, addr, mask} = {g, s, c, b, a, m};
        dq = (c == 3'h4) ? d : ~dq; // Released lanes toggle.
    endtask
endmodule
`default_nettype wire

// [tb/tb_sdp_pin_command_interface.sv]
// Self-checking bench for the pin command block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module tb_sdp_pin_command_interface
    import sdp_pkg::*;
;
    logic             clock;
    logic             sys_rst = 1'b1;
    int               errors = 0;
    int               checked = 0;
    int               seed = 30445;
    int               cycles = 0;
    logic [17:0]      exp_q[$];
    logic [15:0]      ref_mem[logic [9:0]];
    wire logic        gate, cs_n;
    wire logic [2:0]  code;
    wire logic [1:0]  ba, mask, oe;
    wire logic [11:0] addr, mcode;
    wire logic [15:0] hdq, din, dout;
    wire logic [3:0]  bopen;
    sdp_pwr_e         pwr;
    // The shared data lanes carry whichever party drives them.
    assign din = {oe[1] ? dout[15:8] : hdq[15:8], oe[0] ? dout[7:0] : hdq[7:0]};
    sdp_host_model host (.clock, .gate, .cs_n, .code, .ba, .addr, .mask,
        .dq(hdq));
    sdp_pin_if DUT (.clock, .sys_rst, .clock_gate_in(gate),
        .command_select_n(cs_n), .row_strobe_n(code[2]),
        .column_strobe_n(code[1]), .write_strobe_n(code[0]),
        .bank_select(ba), .addr_in(addr), .low_byte_mask(mask[0]),
        .high_byte_mask(mask[1]), .data_in(din), .data_out(dout),
        .data_oe(oe), .bank_open(bopen), .mode_code(mcode), .power_state(pwr));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic close_out();
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) host.cmd(3'h7, 2'h0, 12'h000, 2'h3, 16'h0000);
    endtask
    // Full word, then a masked word over it with address bits 11, 9 and 8 set.
    task automatic wr(input logic [1:0] b, input logic [7:0] c);
        logic [15:0] d1, d2;
        logic [1:0]  m;
        d1 = $random(seed);
        d2 = $random(seed);
        m = 2'($random(seed));
        host.cmd(3'h4, b, {4'h0, c}, 2'h0, d1);
        host.cmd(3'h4, b, {4'hB, c}, m, d2);
        ref_mem[{b, c}] = {m[1] ? d1[15:8] : d2[15:8], m[0] ? d1[7:0] : d2[7:0]};
    endtask
    // Read with a random lane mask one edge later; notes the expected word.
    task automatic rd(input logic [1:0] b, input logic [7:0] c, input logic ap);
        logic [1:0] m;
        m = 2'($random(seed));
        host.cmd(3'h5, b, {1'b1, ap, 2'h3, c}, 2'h0, 16'h0000);
        if (m != 2'h3) exp_q.push_back({~m, ref_mem[{b, c}]
            & {{8{~m[1]}}, {8{~m[0]}}}});
        host.cmd(3'h7, b, 12'h000, m, 16'h0000);
        idle(3);
    endtask
    // Read words are checked against the oldest note; a ceiling cuts hangs.
    always @(negedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            close_out();
        end
        if (oe !== 2'h0) begin
            if (exp_q.size() == 0) `CHK(oe, 2'h0)
            else `CHK({oe, dout & {{8{oe[1]}}, {8{oe[0]}}}}, exp_q.pop_front())
        end
    end
    initial begin
        logic [11:0] op;
        logic [7:0]  c;
        repeat (2) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        op = $random(seed);
        host.cmd(3'h0, 2'h0, op, 2'h3, 16'h0000);
        idle(1);
        `CHK(mcode, op)
        for (int b = 0; b < 4; b++) host.cmd(3'h3, b[1:0], 12'hFFF, 2'h3, 0);
        idle(1);
        `CHK(bopen, 4'hF)
        for (int i = 0; i < 8; i++) begin
            c = $random(seed);
            wr(i[1:0], c);
            rd(i[1:0], c, 1'b0);
        end
        // Deselected commands, then a stopped clock with commands present.
        host.cmd(3'h0, 2'h0, ~op, 2'h3, 0, 1'b1, 1'b1);
        host.cmd(3'h2, 2'h0, 12'h400, 2'h3, 0, 1'b1, 1'b1);
        idle(1);
        `CHK({mcode, bopen}, {op, 4'hF})
        repeat (2) host.cmd(3'h2, 2'h0, 12'h400, 2'h3, 0, 1'b0);
        host.cmd(3'h5, 2'h0, 12'h000, 2'h0, 0, 1'b0);
        `CHK({pwr, bopen}, {SDP_PWR_DOWN, 4'hF})
        idle(2);
        // A read in flight when the gate drops gives clock suspend.
        host.cmd(3'h5, 2'h0, 12'h000, 2'h3, 0);
        repeat (2) host.cmd(3'h7, 2'h0, 12'h000, 2'h3, 0, 1'b0);
        `CHK(pwr, SDP_PWR_SUSPEND)
        idle(4);
        // A refresh command as the gate drops gives self refresh.
        host.cmd(3'h1, 2'h0, 12'h000, 2'h3, 0, 1'b0);
        host.cmd(3'h7, 2'h0, 12'h000, 2'h3, 0, 1'b0);
        `CHK(pwr, SDP_PWR_SELF_REFRESH)
        idle(2);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h00, 1'b1);
        idle(4);
        `CHK(bopen, 4'hD)
        host.cmd(3'h2, 2'h2, 12'h000, 2'h3, 0);
        idle(1);
        `CHK(bopen, 4'h9)
        host.cmd(3'h5, 2'h2, 12'h000, 2'h0, 0);
        host.cmd(3'h2, 2'h0, 12'h400, 2'h0, 0);
        idle(6);
        `CHK({bopen, exp_q.size() == 0}, 5'h01)
        close_out();
    end
endmodule
`default_nettype wire
